// ### inc/adc_hpf_consts.vh
// Register map, field positions, reset values and filter constants for the
// ADC high pass filter, polarity and slot routing block.
// Assumes 24-bit two's-complement samples and an APB register port.
`ifndef ADC_HPF_CONSTS_VH
`define ADC_HPF_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_THERM      6'h02
`define IDX_SRC        6'h04
`define IDX_FILT       6'h0e
`define IDX_IRQ_STAT   6'h10
`define IDX_IRQ_MASK   6'h11

// Field positions
`define THERM_EN_BIT   14
`define SRC_L_BIT      15
`define SRC_R_BIT      14
`define HPF_EN_BIT     8
`define CUT_HI         6
`define CUT_LO         5
`define INV_L_BIT      1
`define INV_R_BIT      0
`define STAT_HOT_BIT   0
`define STAT_SAT_BIT   1
`define STAT_LVL_BIT   8

// Writable field masks and reset values
`define THERM_MASK     16'h4000
`define SRC_MASK       16'hc000
`define FILT_MASK      16'h0163
`define IRQ_MASK_BITS  2'h3
`define THERM_RESET    16'h4000
`define SRC_RESET      16'h4000
`define FILT_RESET     16'h0100

// Cut-off codes and their feedback shifts
`define CUT_HIFI       2'h0
`define CUT_VOICE1     2'h1
`define CUT_VOICE2     2'h2
`define CUT_VOICE3     2'h3
`define SHIFT_HIFI     4'hb
`define SHIFT_VOICE1   4'h4
`define SHIFT_VOICE2   4'h3
`define SHIFT_VOICE3   4'h2

// Sample format
`define FRAC           12
`define SMIN           24'h800000
`define SMAX           24'h7fffff

`endif

// ### rtl/adc_hpf_routing_invert.v
// ADC record path back end: per-channel high pass filter, polarity
// inversion, slot crossbar, thermal status and APB registers.
// Assumes one clock, synchronous inputs and a one-cycle sample strobe at fs.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "adc_hpf_consts.vh"

module hpf_chan (
    input  wire               pclk,        // System clock
    input  wire               presetn,     // Async reset, active low
    input  wire               strobe,      // One pulse per sample
    input  wire               hpf_on,      // Filter enable
    input  wire [1:0]         cut,         // Cut-off code
    input  wire signed [23:0] x,           // Input sample
    output reg  signed [23:0] y_q          // Filtered sample
);
    reg  signed [35:0] dc_q;
    reg         [3:0]  sh;
    wire signed [24:0] diff;
    wire signed [23:0] ys;
    wire signed [35:0] step;

    assign diff = {x[23], x} - {dc_q[35], dc_q[35:`FRAC]};
    assign ys   = (diff[24] != diff[23]) ?
                  {diff[24], {23{~diff[24]}}} : diff[23:0];
    // Shift per sample, so fc tracks fs for every code
    // Signed shift: a plain concatenation would shift in zeros
    assign step = $signed({ys, {`FRAC{1'b0}}}) >>> sh;

    always @* begin
        case (cut)
            `CUT_HIFI:   sh = `SHIFT_HIFI;
            `CUT_VOICE1: sh = `SHIFT_VOICE1;
            `CUT_VOICE2: sh = `SHIFT_VOICE2;
            `CUT_VOICE3: sh = `SHIFT_VOICE3;
            default:     sh = `SHIFT_HIFI;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dc_q <= 36'h000000000;
            y_q  <= 24'h000000;
        end else if (strobe) begin
            if (hpf_on) begin
                dc_q <= dc_q + step;
                y_q  <= ys;
            end else begin
                // Clear the estimate so re-enable starts clean
                dc_q <= 36'h000000000;
                y_q  <= x;
            end
        end
    end
endmodule // hpf_chan

// Polarity stage for one channel
module pol_invert #(
    parameter W = 24                      // Sample width
) (
    input  wire         inv,              // Invert request
    input  wire [W-1:0] din,              // Sample in
    output wire [W-1:0] dout,             // Sample out
    output wire         sat               // Most negative code was clamped
);
    localparam [W-1:0] MOST_NEG = {1'b1, {(W-1){1'b0}}};
    localparam [W-1:0] MOST_POS = {1'b0, {(W-1){1'b1}}};
    localparam [W-1:0] ZERO     = {W{1'b0}};

    // Plain negation would wrap the most negative code back onto itself
    assign sat  = inv & (din == MOST_NEG);
    assign dout = !inv ? din : (sat ? MOST_POS : (ZERO - din));
endmodule // pol_invert

// One software control register with write mask and reset value
module ctrl_reg #(
    parameter [15:0] RESET = 16'h0000,    // Value after reset
    parameter [15:0] MASK  = 16'hffff     // Writable bits
) (
    input  wire        pclk,              // System clock
    input  wire        presetn,           // Async reset, active low
    input  wire        we,                // Write strobe
    input  wire [15:0] wdata,             // Write data
    output reg  [15:0] value_q            // Register contents
);
    // Reserved bits stay zero whatever software writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= RESET;
        end else if (we) begin
            value_q <= wdata & MASK;
        end
    end
endmodule // ctrl_reg

// Overview of operation
// - The high pass filter acts only while its enable bit 8 is set, reset 1.
// - Bits 6:5 pick the cut-off, code 00 at reset being hi-fi DC removal.
// - Codes 01, 10 and 11 pick voice modes 1 to 3 with rising cut-off.
// - Cut-off scales with sample rate, 3.4 Hz in hi-fi at 44.1 kHz.
// - Left slot carries left ADC when bit 15 is 0, right when 1, reset 0.
// - Right slot carries left ADC when bit 14 is 0, right when 1, reset 1.
// - Bit 1 set inverts left ADC samples, clear passes them, reset clear.
// - Bit 0 set inverts right ADC samples, clear passes them, reset clear.
// - The thermal sensor runs only while bit 14 is set, reset 1.
// - Thermal status goes to a pin, a readable register and an interrupt.
module adc_hpf_routing_invert (
    input  wire        pclk,             // 20 MHz clock
    input  wire        presetn,          // Async reset, active low
    input  wire        psel,             // APB select
    input  wire        penable,          // APB enable
    input  wire        pwrite,           // APB direction
    input  wire [7:0]  paddr,            // APB byte address
    input  wire [31:0] pwdata,           // APB write data
    output reg  [31:0] prdata,           // APB read data
    output reg         pready,           // APB ready
    output reg         pslverr,          // APB error, unmapped address
    input  wire        sample_strobe,    // One pulse per sample at fs
    input  wire [23:0] adc_left,         // Left ADC sample
    input  wire [23:0] adc_right,        // Right ADC sample
    output reg  [23:0] aif_left,         // Left interface slot
    output reg  [23:0] aif_right,        // Right interface slot
    output reg         aif_valid,        // Slot data valid pulse
    input  wire        temp_hot,         // Raw sensor over-temperature
    output reg         thermal_sensor_enable, // Sensor power enable
    output reg         temp_ok,          // Status pin, high when cool
    output reg         irq               // Level interrupt
);
    wire [15:0] therm_q;
    wire [15:0] src_q;
    wire [15:0] filt_q;
    reg  [1:0]  stat_q;
    reg  [1:0]  stat_d;
    reg  [1:0]  mask_q;
    reg         hot_q;
    reg         filt_vld_q;
    reg  [31:0] rdata_d;
    reg         hit_d;
    wire [23:0] left_f;
    wire [23:0] right_f;
    wire [23:0] left_i;
    wire [23:0] right_i;
    wire        sat_l;
    wire        sat_r;
    wire        hot_d;
    wire        wr_go;
    wire [5:0]  idx;

    assign idx   = paddr[7:2];
    assign wr_go = psel & penable & pready & pwrite;

    hpf_chan u_hpf_left (
        .pclk    (pclk),
        .presetn (presetn),
        .strobe  (sample_strobe),
        .hpf_on  (filt_q[`HPF_EN_BIT]),
        .cut     (filt_q[`CUT_HI:`CUT_LO]),
        .x       (adc_left),
        .y_q     (left_f)
    );

    hpf_chan u_hpf_right (
        .pclk    (pclk),
        .presetn (presetn),
        .strobe  (sample_strobe),
        .hpf_on  (filt_q[`HPF_EN_BIT]),
        .cut     (filt_q[`CUT_HI:`CUT_LO]),
        .x       (adc_right),
        .y_q     (right_f)
    );

    // Inversion per ADC, ahead of the slot crossbar
    pol_invert #(
        .W    (24)
    ) u_inv_left (
        .inv  (filt_q[`INV_L_BIT]),
        .din  (left_f),
        .dout (left_i),
        .sat  (sat_l)
    );

    pol_invert #(
        .W    (24)
    ) u_inv_right (
        .inv  (filt_q[`INV_R_BIT]),
        .din  (right_f),
        .dout (right_i),
        .sat  (sat_r)
    );

    ctrl_reg #(
        .RESET (`THERM_RESET),
        .MASK  (`THERM_MASK)
    ) u_therm_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (wr_go && idx == `IDX_THERM),
        .wdata   (pwdata[15:0]),
        .value_q (therm_q)
    );

    ctrl_reg #(
        .RESET (`SRC_RESET),
        .MASK  (`SRC_MASK)
    ) u_src_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (wr_go && idx == `IDX_SRC),
        .wdata   (pwdata[15:0]),
        .value_q (src_q)
    );

    ctrl_reg #(
        .RESET (`FILT_RESET),
        .MASK  (`FILT_MASK)
    ) u_filt_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (wr_go && idx == `IDX_FILT),
        .wdata   (pwdata[15:0]),
        .value_q (filt_q)
    );

    // Sensor reads as cool while disabled
    assign hot_d = therm_q[`THERM_EN_BIT] & temp_hot;

    always @* begin
        stat_d = stat_q;
        if (wr_go && idx == `IDX_IRQ_STAT) begin
            stat_d = stat_q & ~pwdata[1:0];
        end
        // Set beats a same-cycle clear
        if (hot_d & ~hot_q) begin
            stat_d[`STAT_HOT_BIT] = 1'b1;
        end
        if (filt_vld_q & (sat_l | sat_r)) begin
            stat_d[`STAT_SAT_BIT] = 1'b1;
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        hit_d   = 1'b1;
        case (idx)
            `IDX_THERM:    rdata_d[15:0] = therm_q;
            `IDX_SRC:      rdata_d[15:0] = src_q;
            `IDX_FILT:     rdata_d[15:0] = filt_q;
            `IDX_IRQ_STAT: begin
                rdata_d[1:0] = stat_q;
                rdata_d[`STAT_LVL_BIT] = hot_q;
            end
            `IDX_IRQ_MASK: rdata_d[1:0] = mask_q;
            default:       hit_d = 1'b0;
        endcase
    end

    // Zero-wait APB: data is captured in setup, ready shows in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_d;
            prdata  <= (psel & ~penable & ~pwrite) ?
                       rdata_d : 32'h00000000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 2'h0;
        end else if (wr_go && idx == `IDX_IRQ_MASK) begin
            mask_q <= pwdata[1:0] & `IRQ_MASK_BITS;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q                <= 2'h0;
            irq                   <= 1'b0;
            hot_q                 <= 1'b0;
            temp_ok               <= 1'b1;
            thermal_sensor_enable <= 1'b1;
        end else begin
            stat_q                <= stat_d;
            irq                   <= |(stat_d & mask_q);
            hot_q                 <= hot_d;
            temp_ok               <= ~hot_d;
            thermal_sensor_enable <= therm_q[`THERM_EN_BIT];
        end
    end

    // Slot crossbar, one cycle behind the filter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_vld_q <= 1'b0;
            aif_valid  <= 1'b0;
            aif_left   <= 24'h000000;
            aif_right  <= 24'h000000;
        end else begin
            filt_vld_q <= sample_strobe;
            aif_valid  <= filt_vld_q;
            if (filt_vld_q) begin
                aif_left  <= src_q[`SRC_L_BIT] ? right_i : left_i;
                aif_right <= src_q[`SRC_R_BIT] ? right_i : left_i;
            end
        end
    end
endmodule // adc_hpf_routing_invert

// ### dv/adc_hpf_routing_invert_assertions.sv
// Port checker for the ADC back end.
// Assumes a bind onto the top module.
`timescale 1ns/1ns
module hpf_chk (
    input wire        pclk,                  // Clock
    input wire        presetn,               // Reset, active low
    input wire        psel,                  // Select
    input wire        penable,               // Enable
    input wire [31:0] prdata,                // Read data
    input wire        pready,                // Ready
    input wire        pslverr,               // Error
    input wire        sample_strobe,         // Strobe
    input wire [23:0] aif_left,              // Left slot
    input wire [23:0] aif_right,             // Right slot
    input wire        aif_valid,             // Slot valid
    input wire        temp_hot,              // Raw hot
    input wire        thermal_sensor_enable, // Sensor on
    input wire        temp_ok                // Cool flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    valid_after_strobe_a: assert property (sample_strobe |-> ##2 aif_valid)
        else $error("slot valid late");
    valid_has_cause_a: assert property (aif_valid |-> $past(sample_strobe, 2))
        else $error("slot valid without strobe");
    slot_hold_a: assert property
        (!aif_valid |-> $stable(aif_left))
        else $error("slot changed without valid");
    right_hold_a: assert property
        (!aif_valid |-> $stable(aif_right))
        else $error("right slot changed without valid");
    hot_flag_a: assert property
        (presetn && temp_hot |=> (temp_ok != thermal_sensor_enable))
        else $error("hot not flagged");
    off_means_ok_a: assert property
        ((!thermal_sensor_enable)[*3] |-> temp_ok)
        else $error("disabled sensor flagged hot");
    cover property (aif_valid);
    cover property (pslverr);
    cover property (!temp_ok);
endmodule // hpf_chk

// ### dv/adc_sample_source.sv
// Far-side model: delivers one ADC sample pair per request.
// Lines invert their data on every cycle outside the strobe cycle.
`timescale 1ns/1ns
module adc_sample_source (
    input  wire        pclk,     // Clock
    input  wire        presetn,  // Reset, active low
    input  wire        go,       // Send one pair
    input  wire [23:0] l_in,     // Left value
    input  wire [23:0] r_in,     // Right value
    output reg         strobe,   // Sample strobe
    output reg  [23:0] adc_l,    // Left sample
    output reg  [23:0] adc_r     // Right sample
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe <= 1'b0;
            adc_l  <= 24'h0;
            adc_r  <= 24'h0;
        end else if (go) begin
            strobe <= 1'b1;
            adc_l  <= l_in;
            adc_r  <= r_in;
        end else begin
            // Stale data must not look valid
            strobe <= 1'b0;
            adc_l  <= ~adc_l;
            adc_r  <= ~adc_r;
        end
    end
endmodule // adc_sample_source

// ### dv/test_adc_hpf_routing_invert.sv
// Self-checking bench for the ADC back end.
// Assumes the register header and the sample source model.
`timescale 1ns/1ns
`include "adc_hpf_consts.vh"
module test_adc_hpf_routing_invert;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg go = 0, temp_hot = 0, er;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [23:0] gl = 0, gr = 0;
    reg [23:0] last [0:3];
    reg [99:0] row [0:4];
    wire [31:0] prdata;
    wire pready, pslverr, strb, aif_valid, tse, temp_ok, irq;
    wire [23:0] al, ar, aif_left, aif_right;
    integer fails = 0, total_checks = 0, i, n;
    localparam [7:0] a_th = {`IDX_THERM, 2'h0}, a_src = {`IDX_SRC, 2'h0};
    localparam [7:0] a_flt = {`IDX_FILT, 2'h0}, a_st = {`IDX_IRQ_STAT, 2'h0};
    localparam [7:0] a_mk = {`IDX_IRQ_MASK, 2'h0};
    always #25 pclk = ~pclk;
    adc_sample_source src (.pclk, .presetn, .go, .l_in(gl), .r_in(gr),
        .strobe(strb), .adc_l(al), .adc_r(ar));
    adc_hpf_routing_invert uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_strobe(strb),
        .adc_left(al), .adc_right(ar), .aif_left, .aif_right, .aif_valid,
        .temp_hot, .thermal_sensor_enable(tse), .temp_ok, .irq);
    task tally_and_finish;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input ok, input [8*16-1:0] m);
        begin
            total_checks = total_checks + 1;
            if (ok !== 1'b1) begin
                fails = fails + 1;
                $display("mismatch at %0t: %0s", $time, m);
            end
        end
    endtask
    task wt(input sig);
        begin
            if (n >= 9) begin
                fails = fails + 1;
                $display("mismatch at %0t: timeout", $time);
                tally_and_finish;
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk) penable <= 1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 9) begin
                n = n + 1;
                @(posedge pclk);
            end
            wt(1'b0);
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
            @(posedge pclk);
        end
    endtask
    task smp(input [23:0] l, input [23:0] r);
        begin
            gl <= l;
            gr <= r;
            go <= 1;
            @(posedge pclk) go <= 0;
            n = 0;
            while (aif_valid !== 1'b1 && n < 9) begin
                n = n + 1;
                @(posedge pclk);
            end
            wt(1'b0);
        end
    endtask
    initial begin
        row[0] = {4'h4, 24'h123456, 24'h654321, 24'h123456, 24'h654321};
        row[1] = {4'h8, 24'h123456, 24'h654321, 24'h654321, 24'h123456};
        row[2] = {4'h6, 24'h000010, 24'h000020, 24'hfffff0, 24'h000020};
        row[3] = {4'hd, 24'h000005, 24'h800000, 24'h7fffff, 24'h7fffff};
        row[4] = {4'h7, 24'h7fffff, 24'h000001, 24'h800001, 24'hffffff};
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, a_th, 0);
        chk(rd === 32'h4000, "therm reset");
        apb(0, a_src, 0);
        chk(rd === 32'h4000, "source reset");
        apb(0, a_flt, 0);
        chk(rd === 32'h0100, "filter reset");
        apb(0, 8'h00, 0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped");
        apb(1, a_flt, 32'hffff);
        apb(0, a_flt, 0);
        chk(rd === 32'h0163, "reserved bits");
        for (i = 0; i < 5; i = i + 1) begin
            apb(1, a_src, {16'h0, row[i][99:98], 14'h0});
            apb(1, a_flt, {30'h0, row[i][97:96]});
            smp(row[i][95:72], row[i][71:48]);
            chk(aif_left === row[i][47:24], "left slot");
            chk(aif_right === row[i][23:0], "right slot");
        end
        apb(0, a_st, 0);
        chk(rd[1] === 1'b1, "saturation flag");
        for (i = 0; i < 4; i = i + 1) begin
            apb(1, a_flt, 0);
            // One bypassed sample clears the DC estimate
            smp(24'h100000, 24'h100000);
            chk(aif_left === 24'h100000, "bypass");
            // Voice codes assume an fs low enough for a cut-off under 300 Hz
            apb(1, a_flt, {23'h1, 1'b0, i[1:0], 5'h0});
            repeat (6) smp(24'h100000, 24'h100000);
            last[i] = aif_left;
            chk(last[i] < 24'h100000, "no decay");
            if (i > 0)
                chk(last[i] < last[i-1], "cut-off order");
        end
        apb(1, a_mk, 1);
        temp_hot <= 1;
        repeat (3) @(posedge pclk);
        chk(temp_ok === 1'b0 && irq === 1'b1, "hot event");
        temp_hot <= 0;
        repeat (3) @(posedge pclk);
        chk(irq === 1'b1, "sticky");
        apb(1, a_st, 1);
        @(posedge pclk);
        chk(irq === 1'b0, "cleared");
        apb(1, a_mk, 0);
        // Host would shut down here; this block never does
        temp_hot <= 1;
        repeat (3) @(posedge pclk);
        chk(temp_ok === 1'b0 && irq === 1'b0, "masked");
        apb(1, a_th, 0);
        repeat (3) @(posedge pclk);
        chk(temp_ok === 1'b1 && tse === 1'b0, "sensor off");
        presetn <= 0;
        repeat (2) @(posedge pclk);
        chk(aif_left === 24'h0 && tse === 1'b1, "mid reset");
        temp_hot <= 0;
        presetn <= 1;
        @(posedge pclk);
        apb(0, a_th, 0);
        chk(rd === 32'h4000 && irq === 1'b0, "reset reload");
        tally_and_finish;
    end
endmodule // test_adc_hpf_routing_invert
bind adc_hpf_routing_invert hpf_chk chk (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .sample_strobe, .aif_left, .aif_right,
    .aif_valid, .temp_hot, .thermal_sensor_enable, .temp_ok);
